// ==== rtl/pcint_pkg.sv ====
package pcint_pkg;

    // Port geometry and register layout.
    localparam int          PCINT_PINS      = 6;
    localparam int          PCINT_REG_W     = 8;
    localparam int          PCINT_ADDR_W    = 8;
    localparam logic [7:0]  RISE_EN_OFS     = 8'h00;
    localparam logic [7:0]  FALL_EN_OFS     = 8'h04;
    localparam logic [7:0]  FLAG_OFS        = 8'h08;
    localparam logic [7:0]  INT_CTRL_OFS    = 8'h0c;
    localparam logic [7:0]  INT_STATUS_OFS  = 8'h10;
    localparam logic [7:0]  INT_CLEAR_OFS   = 8'h14;
    localparam logic [7:0]  INT_ENABLE_OFS  = 8'h18;
    localparam logic [5:0]  PIN_RESET       = 6'h00;
    localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

    // Bit positions inside the interrupt control register.
    localparam int          MASTER_EN_BIT   = 0;
    localparam int          SUMMARY_BIT     = 1;
    localparam int          WAKE_BIT        = 2;

    // Events of the interrupt status register.
    localparam int          EVT_W           = 2;
    localparam int          EVT_EDGE        = 0;
    localparam int          EVT_WAKE        = 1;
    localparam logic [1:0]  EVT_RESET       = 2'h0;

    // AHB-Lite encodings used by the slave.
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ      = 2'h3;

    // Latched address phase of one bus transfer.
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } pcint_aphase_t;

endpackage : pcint_pkg

// ==== rtl/pcint_pin_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser per pin plus one history stage for edge comparison.
module pcint_pin_sync
    import pcint_pkg::*;
#(
    parameter int WIDTH = PCINT_PINS
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             arst_n,
    // Raw pins and results.
    input  wire logic [WIDTH-1:0] pinAsync,
    output logic      [WIDTH-1:0] riseSeen,
    output logic      [WIDTH-1:0] fallSeen
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;

    // The history stage reads only the second flop, never the first.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pinAsync;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // One-cycle edge pulses per pin.
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gEdge
            assign riseSeen[g] = sync_q[g] & ~prev_q[g];
            assign fallSeen[g] = ~sync_q[g] & prev_q[g];
        end
    endgenerate

endmodule : pcint_pin_sync

// ==== rtl/pcint_ctrl.sv ====
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
// Functional notes
// - With master enable set, an enabled edge raises a wake request out of sleep.
// - Edges during sleep are flagged in the same cycle as wake is signalled to the core.
// - Rising enable bit 1 arms rising detection on its pin; 0 ignores.
// - Falling enable bit 1 arms falling detection on its pin; 0 ignores.
// - Flag sets on an enabled rising or falling edge of its pin.
// - Any set pin flag also shows in the summary change flag.
// - Flags hold until software writes 0 to them.
// - Bits 7 and 6 of enable and flag registers read zero.
// - All enables and flags clear on every reset.
// - An edge during a flag write leaves that flag set.
// - Detection continues with master enable clear; changeIrq and enabled status events on irqOut still assert, but no wakeReq results.
// - Both enables set detects edges in either direction.
module pcint_ctrl
    import pcint_pkg::*;
#(
    parameter int NPINS = PCINT_PINS
) (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Port pins and sleep state.
    input  wire logic [5:0]  portPinN,
    input  wire logic        cpuSleep,
    // Interrupt and wake outputs.
    output logic             changeIrq,
    output logic             wakeReq,
    output logic             irqOut
);

    initial begin
        if (NPINS != PCINT_PINS) $error("pcint_ctrl serves exactly six pins");
    end

    logic [5:0]    riseSeen;
    logic [5:0]    fallSeen;
    logic [5:0]    edgeHit;
    logic [1:0]    sleepSync_q;
    logic          sleepS;
    pcint_aphase_t ap_q, ap_d;
    logic [5:0]    riseEn_q, riseEn_d;
    logic [5:0]    fallEn_q, fallEn_d;
    logic [5:0]    flag_q, flag_d;
    logic          masterEn_q, masterEn_d;
    logic [1:0]    evtStat_q, evtStat_d;
    logic [1:0]    evtEn_q, evtEn_d;
    logic [31:0]   hrdata_q, hrdata_d;
    logic          changeIrq_q, changeIrq_d;
    logic          wakeReq_q, wakeReq_d;
    logic          irqOut_q, irqOut_d;
    logic          wrFire;
    logic [1:0]    evtNow;

    // Pin synchroniser and edge comparison.
    // sync and compare
    pcint_pin_sync #(
        .WIDTH (PCINT_PINS)
    ) uSync (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .pinAsync (portPinN),
        .riseSeen (riseSeen),
        .fallSeen (fallSeen)
    );

    // The sleep level comes from the core's other logic, so it is synchronised too.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sleepSync_q <= '0;
        end else begin
            sleepSync_q <= {sleepSync_q[0], cpuSleep};
        end
    end
    assign sleepS = sleepSync_q[1];

    // Enabled edges per pin; detection runs regardless of master enable.
    // rising and falling arm
    assign edgeHit = (riseSeen & riseEn_q) | (fallSeen & fallEn_q);

    // A write lands in the data phase that follows the latched address phase.
    assign wrFire = ap_q.valid & ap_q.write;

    // Bus address phase capture; the slave is always ready, so no wait states.
    always_comb begin
        ap_d = ap_q;
        if (hready) begin
            ap_d.valid = hsel & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
            ap_d.write = hwrite;
            ap_d.addr  = haddr[7:0];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ap_q <= '0;
        end else begin
            ap_q <= ap_d;
        end
    end

    // Register state: enables, flags, master enable and interrupt event bits.
    always_comb begin
        riseEn_d   = riseEn_q;
        fallEn_d   = fallEn_q;
        flag_d     = flag_q;
        masterEn_d = masterEn_q;
        evtStat_d  = evtStat_q;
        evtEn_d    = evtEn_q;
        evtNow     = EVT_RESET;
        if (wrFire) begin
            case (ap_q.addr)
                RISE_EN_OFS:    riseEn_d   = hwdata[5:0];
                FALL_EN_OFS:    fallEn_d   = hwdata[5:0];
                FLAG_OFS:       flag_d     = hwdata[5:0];
                INT_CTRL_OFS:   masterEn_d = hwdata[MASTER_EN_BIT];
                INT_CLEAR_OFS:  evtStat_d  = evtStat_q & ~hwdata[EVT_W-1:0];
                INT_ENABLE_OFS: evtEn_d    = hwdata[EVT_W-1:0];
                default:        ;
            endcase
        end
        flag_d = flag_d | edgeHit;
        evtNow[EVT_EDGE] = |edgeHit;
        evtNow[EVT_WAKE] = (|edgeHit) & masterEn_q & sleepS;
        // Events win over a clear in the same cycle so none is lost.
        evtStat_d = evtStat_d | evtNow;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            riseEn_q   <= PIN_RESET;
            fallEn_q   <= PIN_RESET;
            flag_q     <= PIN_RESET;
            masterEn_q <= 1'b0;
            evtStat_q  <= EVT_RESET;
            evtEn_q    <= EVT_RESET;
        end else begin
            riseEn_q   <= riseEn_d;
            fallEn_q   <= fallEn_d;
            flag_q     <= flag_d;
            masterEn_q <= masterEn_d;
            evtStat_q  <= evtStat_d;
            evtEn_q    <= evtEn_d;
        end
    end

    // Read data and outputs, all registered; reads return the state after this cycle's update.
    always_comb begin
        hrdata_d = WORD_ZERO;
        if (hready && hsel && !hwrite && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)) begin
            case (haddr[7:0])
                RISE_EN_OFS:    hrdata_d[5:0] = riseEn_d;
                FALL_EN_OFS:    hrdata_d[5:0] = fallEn_d;
                FLAG_OFS:       hrdata_d[5:0] = flag_d;
                INT_CTRL_OFS: begin
                    hrdata_d[MASTER_EN_BIT] = masterEn_d;
                    hrdata_d[SUMMARY_BIT]   = |flag_d;
                    hrdata_d[WAKE_BIT]      = masterEn_d & (|flag_d) & sleepS;
                end
                INT_STATUS_OFS: hrdata_d[EVT_W-1:0] = evtStat_d;
                INT_ENABLE_OFS: hrdata_d[EVT_W-1:0] = evtEn_d;
                default:        hrdata_d = WORD_ZERO;
            endcase
        end
        changeIrq_d = |flag_d;
        wakeReq_d   = masterEn_d & (|flag_d) & sleepS;
        irqOut_d    = |(evtStat_d & evtEn_d) | (masterEn_d & (|flag_d));
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata_q    <= WORD_ZERO;
            changeIrq_q <= 1'b0;
            wakeReq_q   <= 1'b0;
            irqOut_q    <= 1'b0;
        end else begin
            hrdata_q    <= hrdata_d;
            changeIrq_q <= changeIrq_d;
            wakeReq_q   <= wakeReq_d;
            irqOut_q    <= irqOut_d;
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign changeIrq = changeIrq_q;
    assign wakeReq   = wakeReq_q;
    assign irqOut    = irqOut_q;

endmodule : pcint_ctrl

// ==== testbench/pcint_ctrl_sva.sv ====
`timescale 1ns/1ps
module pcint_ctrl_sva
    import pcint_pkg::*;
(
    // Clock and reset.
    input wire logic        mclk,
    input wire logic        arst_n,
    // Bus and pins.
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [5:0]  portPinN,
    input wire logic        cpuSleep,
    // Watched outputs.
    input wire logic        changeIrq,
    input wire logic        wakeReq,
    input wire logic        irqOut
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic [5:0] pinPrev_q;
    logic [7:0] chg_q;
    logic [7:0] chg_d;
    logic [3:0] quiet_q;
    logic [3:0] quiet_d;
    logic       flagWr;
    // A flag write is taken at its address phase.
    assign flagWr = hsel && hready && hwrite && htrans[1] && (haddr[7:0] == FLAG_OFS);
    // Quiet time counts cycles with no pin change and no bus request.
    always_comb begin
        chg_d = {chg_q[6:0], portPinN != pinPrev_q};
        quiet_d = (chg_d != 8'h00 || htrans[1]) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
    end
    // History registers.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pinPrev_q <= PIN_RESET;
            chg_q <= 8'h00;
            quiet_q <= 4'h0;
        end else begin
            pinPrev_q <= portPinN;
            chg_q <= chg_d;
            quiet_q <= quiet_d;
        end
    end
    AST_RESET_QUIET: assert property ($rose(arst_n) |-> !changeIrq && !wakeReq && !irqOut)
        else $error("outputs active right after reset");
    AST_FLAG_NEEDS_EDGE: assert property ($rose(changeIrq) |-> chg_q != 8'h00)
        else $error("summary flag rose without a pin change");
    AST_CHG_FALL: assert property ($fell(changeIrq) |-> $past(flagWr, 2) || $past(flagWr, 3) || $past(flagWr, 4))
        else $error("summary flag fell without a flag write");
    AST_WAKE_SLEEP: assert property (wakeReq |-> $past(cpuSleep, 2) || $past(cpuSleep, 3) || $past(cpuSleep, 4))
        else $error("wake request while awake");
    AST_NO_WAKE_AWAKE: assert property (!cpuSleep [*6] |-> !wakeReq)
        else $error("wake request held while awake");
    AST_WAKE_FLAG: assert property (wakeReq |-> changeIrq)
        else $error("wake request without a recorded flag");
    AST_WAKE_IRQ: assert property (wakeReq |-> irqOut)
        else $error("wake request without interrupt");
    AST_QUIET: assert property (quiet_q >= 4'h6 |-> $stable(changeIrq) && $stable(irqOut))
        else $error("outputs moved with pins and bus quiet");
    COV_WAKE: cover property (wakeReq);
    COV_NO_IRQ: cover property (changeIrq && !irqOut);
    COV_CLEAR: cover property ($fell(changeIrq));
endmodule : pcint_ctrl_sva

bind pcint_ctrl pcint_ctrl_sva i_sva (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .portPinN(portPinN), .cpuSleep(cpuSleep),
    .changeIrq(changeIrq), .wakeReq(wakeReq), .irqOut(irqOut));

// ==== testbench/pcint_pin_model.sv ====
`timescale 1ns/1ps
// Port pins and core sleep line; they move just after a clock edge.
module pcint_pin_model
    import pcint_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic [5:0] pinLvl,
    input  wire logic       sleepLvl,
    output logic      [5:0] portPinN = PIN_RESET,
    output logic            cpuSleep = 1'b0
);
    // Registered so the pins never change on the sampling instant.
    always_ff @(posedge mclk) begin
        portPinN <= pinLvl;
        cpuSleep <= sleepLvl;
    end
endmodule : pcint_pin_model

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import pcint_pkg::*;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = WORD_ZERO;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = WORD_ZERO;
    logic [5:0]  pinLvl = PIN_RESET;
    logic        sleepLvl = 1'b0;
    logic [31:0] seen;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, changeIrq, wakeReq, irqOut, cpuSleep;
    wire  [5:0]  portPinN;
    int          fail_count = 0;
    int          n_tests = 0;
    // Clock at 4 ns.
    initial begin
        forever #2 mclk = ~mclk;
    end
    pcint_ctrl i_dut (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .portPinN(portPinN), .cpuSleep(cpuSleep),
        .changeIrq(changeIrq), .wakeReq(wakeReq), .irqOut(irqOut));
    pcint_pin_model i_pins (.mclk(mclk), .pinLvl(pinLvl), .sleepLvl(sleepLvl), .portPinN(portPinN),
        .cpuSleep(cpuSleep));
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Waits for hready at an edge; a lost slave ends the run.
    task automatic ready_edge();
        int i;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 16);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            final_report();
        end
    endtask : ready_edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h0, a};
        ready_edge();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        ready_edge();
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, a, d, unused);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] got;
        bus(1'b0, a, WORD_ZERO, got);
        check(what, got, exp);
        check("bus response", {31'h0, hresp}, WORD_ZERO);
    endtask : rd
    // Pin change, then the four-edge path plus margin.
    task automatic pin(input logic [5:0] v);
        pinLvl <= v;
        repeat (8) @(posedge mclk);
    endtask : pin
    task automatic outs(input logic [2:0] exp);
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        check("irq wake out", {29'h0, changeIrq, wakeReq, irqOut}, {29'h0, exp});
        @(posedge mclk);
    endtask : outs
    // Hang guard.
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        for (int k = 0; k < 8; k++) rd(8'(4 * k), WORD_ZERO, "reset value");
        wr(RISE_EN_OFS, 32'hffff_ffff);
        rd(RISE_EN_OFS, 32'h3f, "rise enable");
        pin(6'h3f);
        rd(FLAG_OFS, 32'h3f, "flag rise");
        outs(3'b100);
        rd(INT_STATUS_OFS, 32'h1, "status");
        wr(INT_ENABLE_OFS, 32'h1);
        outs(3'b101);
        wr(INT_CLEAR_OFS, 32'h1);
        rd(INT_STATUS_OFS, WORD_ZERO, "status cleared");
        outs(3'b100);
        wr(INT_ENABLE_OFS, WORD_ZERO);
        rd(FLAG_OFS, 32'h3f, "flag sticky");
        // Write the seen value masked by its own inverse, which is zero, so every flag is cleared.
        bus(1'b0, FLAG_OFS, WORD_ZERO, seen);
        wr(FLAG_OFS, seen & (seen ^ 32'hff));
        rd(FLAG_OFS, WORD_ZERO, "flag cleared");
        pin(6'h00);
        rd(FLAG_OFS, WORD_ZERO, "fall off");
        wr(FALL_EN_OFS, 32'h15);
        wr(RISE_EN_OFS, WORD_ZERO);
        pin(6'h3f);
        rd(FLAG_OFS, WORD_ZERO, "rise off");
        wr(RISE_EN_OFS, 32'h3f);
        pin(6'h00);
        rd(FLAG_OFS, 32'h15, "fall on");
        sleepLvl <= 1'b1;
        wr(INT_CTRL_OFS, 32'h1);
        pin(6'h3f);
        outs(3'b111);
        rd(FLAG_OFS, 32'h3f, "flag in sleep");
        rd(INT_CTRL_OFS, 32'h7, "control");
        rd(INT_STATUS_OFS, 32'h3, "status sleep");
        sleepLvl <= 1'b0;
        wr(FLAG_OFS, WORD_ZERO);
        outs(3'b000);
        wr(8'h1c, 32'hffff_ffff);
        rd(8'h1c, WORD_ZERO, "unmapped");
        final_report();
    end
endmodule : testbench
